// ==== hw/flash_host_pkg.sv ====
// package: register fields, command codes and timing for the flash status host
package flash_host_pkg;
    // status word fields
    localparam int sr_ready_bit = 7;
    localparam int sr_erase_susp_bit = 6;
    localparam int sr_erase_err_bit = 5;
    localparam int sr_prog_err_bit = 4;
    localparam int sr_supply_low_bit = 3;
    localparam int sr_prog_susp_bit = 2;
    localparam int sr_lock_viol_bit = 1;
    localparam logic [15:0] sr_valid_mask = 16'h00fe;
    // extended status word
    localparam int xsr_buf_avail_bit = 7;
    localparam logic [15:0] xsr_valid_mask = 16'h0080;
    // partition layout register
    localparam int pcr_code_lsb = 8;
    localparam logic [15:0] pcr_valid_mask = 16'h0700;
    localparam logic [2:0] pc_none = 3'h0;
    localparam logic [2:0] pc_four = 3'h7;
    localparam logic [2:0] pc_bottom_default = 3'h1;
    localparam logic [2:0] pc_top_default = 3'h4;
    // command codes written on the data bus
    localparam logic [15:0] cmd_read_status = 16'h0070;
    localparam logic [15:0] cmd_clear_status = 16'h0050;
    localparam logic [15:0] cmd_read_id = 16'h0090;
    localparam logic [15:0] cmd_buf_program = 16'h00e8;
    localparam logic [15:0] cmd_read_array = 16'h00ff;
    // address in identifier space where the layout register reads out
    localparam logic [20:0] pcr_id_addr = 21'h000006;
    // bus timing
    localparam int clock_mhz = 250;
    localparam int bus_phase_ns = 60;
    localparam int bus_phase_cycles = (bus_phase_ns * clock_mhz + 999) / 1000;
    localparam logic [7:0] phase_count = 8'(bus_phase_cycles);
    localparam logic [7:0] buf_retry_limit = 8'h10;
    // user command kinds
    typedef enum logic [1:0] {op_poll_status, op_read_ext, op_read_layout, op_clear} op_t;
endpackage : flash_host_pkg

// ==== hw/flash_bus_cycle.sv ====
// one asynchronous flash bus read or write cycle, timed in clock cycles
`timescale 1ns/10ps
module flash_bus_cycle
    import flash_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic write,
    input wire logic [20:0] addr,
    input wire logic [15:0] wdata,
    input wire logic [15:0] dq_in,
    output logic [20:0] flash_addr,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [15:0] rdata,
    output logic done
);
    typedef enum logic [1:0] {idle_s, strobe_s, recover_s} cyc_t;
    cyc_t state;
    cyc_t next_state;
    logic [7:0] count;
    logic [7:0] next_count;
    logic is_write;
    logic next_is_write;
    logic [15:0] next_rdata;
    logic [20:0] next_flash_addr;
    logic [15:0] next_dq_out;

    // strobe held one phase, then one phase of recovery before done
    always_comb
    begin
        next_state = state;
        next_count = count;
        next_is_write = is_write;
        next_rdata = rdata;
        next_flash_addr = flash_addr;
        next_dq_out = dq_out;
        done = 1'b0;
        unique case (state)
            idle_s:
            begin
                if (start)
                begin
                    next_state = strobe_s;
                    next_count = phase_count;
                    next_is_write = write;
                    next_flash_addr = addr;
                    next_dq_out = wdata;
                end
            end
            strobe_s:
            begin
                if (count == 8'h01)
                begin
                    next_state = recover_s;
                    next_count = phase_count;
                    if (!is_write)
                        next_rdata = dq_in; // sample at end of read strobe
                end
                else
                    next_count = count - 8'h01;
            end
            recover_s:
            begin
                if (count == 8'h01)
                begin
                    next_state = idle_s;
                    done = 1'b1;
                end
                else
                    next_count = count - 8'h01;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= idle_s;
            count <= 8'h00;
            is_write <= 1'b0;
            rdata <= 16'h0000;
            flash_addr <= 21'h000000;
            dq_out <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            count <= next_count;
            is_write <= next_is_write;
            rdata <= next_rdata;
            flash_addr <= next_flash_addr;
            dq_out <= next_dq_out;
        end
    end

    // chip enable spans strobe and recovery so data stays driven past we_n rise
    assign ce_n = (state == idle_s);
    assign oe_n = !(state == strobe_s && !is_write);
    assign we_n = !(state == strobe_s && is_write);
    assign dq_oe_n = !((state != idle_s) && is_write);
endmodule : flash_bus_cycle

// ==== hw/flash_status_host.sv ====
// host controller that polls the flash status, extended status and layout registers
`timescale 1ns/10ps
module flash_status_host
    import flash_host_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // user side
    input wire logic req_valid,
    input wire op_t req_op,
    input wire logic [20:0] req_addr,
    output logic req_ready,
    output logic resp_valid,
    output logic seq_ready,
    output logic erase_suspended,
    output logic erase_error,
    output logic program_error,
    output logic supply_low,
    output logic program_suspended,
    output logic lock_violation,
    output logic bad_sequence,
    output logic buffer_available,
    output logic [2:0] partition_code,
    output logic [2:0] partition_count,
    output logic concurrent_allowed,
    output logic timeout,
    // flash pins
    input wire logic ready_busy_output,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic [20:0] flash_addr,
    output logic ce_n,
    output logic oe_n,
    output logic we_n
);
    typedef enum logic [2:0] {idle_s, cmd_s, read_s, wait_pin_s, done_s} host_t;
    host_t state;
    host_t next_state;
    op_t op;
    op_t next_op;
    logic [20:0] addr;
    logic [20:0] next_addr;
    logic [7:0] retries;
    logic [7:0] next_retries;
    logic [15:0] sr;
    logic [15:0] next_sr;
    logic [15:0] extended_status_word;
    logic [15:0] next_xsr;
    logic [15:0] partition_layout_config;
    logic [15:0] next_pcr;
    logic timeout_q;
    logic next_timeout;
    logic bus_start;
    logic bus_write;
    logic [20:0] bus_addr;
    logic [15:0] bus_wdata;
    logic [15:0] bus_rdata;
    logic bus_done;
    logic [15:0] sr_m;
    logic [15:0] xsr_m;
    logic [15:0] pcr_m;

    flash_bus_cycle u_cycle (
        .clock(clock),
        .rst(rst),
        .start(bus_start),
        .write(bus_write),
        .addr(bus_addr),
        .wdata(bus_wdata),
        .dq_in(dq_in),
        .flash_addr(flash_addr),
        .dq_out(dq_out),
        .dq_oe_n(dq_oe_n),
        .ce_n(ce_n),
        .oe_n(oe_n),
        .we_n(we_n),
        .rdata(bus_rdata),
        .done(bus_done)
    );

    // command for each operation; read of status goes to the partition address
    always_comb
    begin
        bus_addr = addr;
        bus_write = (state == cmd_s);
        bus_start = (state == cmd_s || state == read_s) && !bus_done;
        unique case (op)
            op_poll_status: bus_wdata = cmd_read_status;
            op_read_ext: bus_wdata = cmd_buf_program;
            op_read_layout: bus_wdata = cmd_read_id;
            op_clear: bus_wdata = cmd_clear_status;
        endcase
        if (state == read_s && op == op_read_layout)
            bus_addr = pcr_id_addr;
    end

    // start stays high while the cycle runs and drops only with done, because the cycle ignores it outside idle
    always_comb
    begin
        next_state = state;
        next_op = op;
        next_addr = addr;
        next_retries = retries;
        next_sr = sr;
        next_xsr = extended_status_word;
        next_pcr = partition_layout_config;
        next_timeout = timeout_q;
        unique case (state)
            idle_s:
            begin
                if (req_valid)
                begin
                    next_op = req_op;
                    next_addr = req_addr;
                    next_retries = buf_retry_limit;
                    next_timeout = 1'b0;
                    next_state = cmd_s;
                end
            end
            cmd_s:
            begin
                if (bus_done)
                    next_state = (op == op_clear) ? done_s : read_s;
            end
            read_s:
            begin
                if (bus_done)
                begin
                    next_state = done_s;
                    unique case (op)
                        op_poll_status:
                        begin
                            next_sr = bus_rdata & sr_valid_mask;
                            if (!bus_rdata[sr_ready_bit])
                                next_state = wait_pin_s;
                        end
                        op_read_ext:
                        begin
                            next_xsr = bus_rdata & xsr_valid_mask;
                            if (!bus_rdata[xsr_buf_avail_bit])
                            begin
                                // reissue buffer command to recheck availability
                                if (retries == 8'h00)
                                    next_timeout = 1'b1;
                                else
                                begin
                                    next_retries = retries - 8'h01;
                                    next_state = cmd_s;
                                end
                            end
                        end
                        op_read_layout: next_pcr = bus_rdata & pcr_valid_mask;
                        op_clear: next_state = done_s;
                    endcase
                end
            end
            wait_pin_s:
            begin
                if (ready_busy_output)
                    next_state = read_s;
            end
            done_s: next_state = idle_s;
        endcase
    end

    // layout reset value is the bottom variant until first readback
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= idle_s;
            op <= op_poll_status;
            addr <= 21'h000000;
            retries <= 8'h00;
            sr <= 16'h0000;
            extended_status_word <= 16'h0000;
            partition_layout_config <= {5'h00, pc_bottom_default, 8'h00};
            timeout_q <= 1'b0;
        end
        else
        begin
            state <= next_state;
            op <= next_op;
            addr <= next_addr;
            retries <= next_retries;
            sr <= next_sr;
            extended_status_word <= next_xsr;
            partition_layout_config <= next_pcr;
            timeout_q <= next_timeout;
        end
    end

    assign req_ready = (state == idle_s);
    assign resp_valid = (state == done_s);
    assign timeout = timeout_q;
    assign sr_m = sr;
    assign xsr_m = extended_status_word;
    assign pcr_m = partition_layout_config;

    // decoded status; error bits gated by ready because they are invalid while busy
    assign seq_ready = sr_m[sr_ready_bit];
    assign erase_suspended = seq_ready && sr_m[sr_erase_susp_bit];
    assign erase_error = seq_ready && sr_m[sr_erase_err_bit] && !sr_m[sr_prog_err_bit];
    assign program_error = seq_ready && sr_m[sr_prog_err_bit] && !sr_m[sr_erase_err_bit];
    assign bad_sequence = seq_ready && sr_m[sr_erase_err_bit] && sr_m[sr_prog_err_bit];
    assign supply_low = seq_ready && sr_m[sr_supply_low_bit];
    assign program_suspended = seq_ready && sr_m[sr_prog_susp_bit];
    assign lock_violation = seq_ready && sr_m[sr_lock_viol_bit];
    assign buffer_available = xsr_m[xsr_buf_avail_bit];
    assign partition_code = pcr_m[pcr_code_lsb +: 3];

    // partition count per layout code
    always_comb
    begin
        unique case (partition_code)
            3'h0: partition_count = 3'h1;
            3'h1, 3'h2, 3'h4: partition_count = 3'h2;
            3'h3, 3'h5, 3'h6: partition_count = 3'h3;
            3'h7: partition_count = 3'h4;
        endcase
    end
    assign concurrent_allowed = (partition_code != pc_none);
endmodule : flash_status_host

// ==== verif/flash_status_host_chk.sv ====
// port checks for the flash status host
`timescale 1ns/10ps
module flash_status_host_chk
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic resp_valid,
    input wire logic seq_ready,
    input wire logic erase_suspended,
    input wire logic erase_error,
    input wire logic program_error,
    input wire logic supply_low,
    input wire logic program_suspended,
    input wire logic lock_violation,
    input wire logic bad_sequence,
    input wire logic [2:0] partition_code,
    input wire logic [2:0] partition_count,
    input wire logic concurrent_allowed,
    input wire logic dq_oe_n,
    input wire logic oe_n,
    input wire logic we_n
);
    default clocking dcb @(posedge clock);
    endclocking
    default disable iff (rst);
    logic any_flag;
    // any flag that is meaningless while the sequencer is busy
    assign any_flag = erase_suspended | erase_error | program_error | supply_low | program_suspended
        | lock_violation | bad_sequence;
    a_busy_hides_flags: assert property (!seq_ready |-> !any_flag)
        else $error("flags shown while busy");
    a_bad_seq_errs: assert property (bad_sequence |-> !erase_error && !program_error)
        else $error("error flags beside bad sequence");
    a_one_part: assert property (partition_code == 3'h0 |-> !concurrent_allowed && partition_count == 3'h1)
        else $error("code 0 decode wrong");
    a_two_parts: assert property (partition_code inside {3'h1, 3'h2, 3'h4} |->
        concurrent_allowed && partition_count == 3'h2)
        else $error("two partition decode wrong");
    a_three_parts: assert property (partition_code inside {3'h3, 3'h5, 3'h6} |->
        concurrent_allowed && partition_count == 3'h3)
        else $error("three partition decode wrong");
    a_four_parts: assert property (partition_code == 3'h7 |-> concurrent_allowed && partition_count == 3'h4)
        else $error("four partition decode wrong");
    a_resp_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("response held too long");
    a_strobes_apart: assert property (!(oe_n == 1'b0 && we_n == 1'b0))
        else $error("read and write strobes together");
    // the data pins must be driven for the whole write strobe and released for reads
    a_write_drives_dq: assert property (!we_n |-> !dq_oe_n)
        else $error("write strobe without data drive");
    a_read_frees_dq: assert property (!oe_n |-> dq_oe_n)
        else $error("data driven during read strobe");
    // after the answer the block must take the next request
    a_ready_after_resp: assert property (resp_valid |=> req_ready)
        else $error("not ready after response");
endmodule : flash_status_host_chk

bind flash_status_host flash_status_host_chk chk_u (.clock, .rst, .req_ready, .resp_valid, .seq_ready,
    .erase_suspended, .erase_error, .program_error, .supply_low, .program_suspended, .lock_violation,
    .bad_sequence, .partition_code, .partition_count, .concurrent_allowed, .dq_oe_n, .oe_n, .we_n);

// ==== verif/flash_dev_model.sv ====
// behavioural flash device holding status, extended status and layout registers
`timescale 1ns/10ps
module flash_dev_model
    import flash_host_pkg::*;
(
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [20:0] flash_addr,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in,
    output logic ready_busy_output
);
    logic [15:0] sr [2] = '{16'h0080, 16'h0080};
    logic [15:0] cmd = 16'h00ff;
    logic [15:0] rd;
    logic [15:0] last = 16'h0000;
    logic [15:0] junk = 16'h0000; // reserved bits zero unless a test sets them
    logic [2:0] partition_layout_config = pc_bottom_default;
    logic [4:0] e8_count = 5'h0;
    logic [4:0] avail_after = 5'h1;
    logic sel = 1'b0;
    // command taken at the rising write strobe; clear drops flags of both partitions
    always @(posedge we_n)
    begin
        if (!ce_n)
        begin
            cmd = dq_out;
            sel = flash_addr[20];
            e8_count = (dq_out == cmd_buf_program) ? e8_count + 5'h1 : 5'h0;
            if (dq_out == cmd_clear_status)
            begin
                sr[0] = sr[0] & 16'hff81;
                sr[1] = sr[1] & 16'hff81;
            end
        end
    end
    // read data chosen by the last command
    always_comb
    begin
        case (cmd)
            cmd_read_status: rd = sr[flash_addr[20]];
            cmd_buf_program: rd = (e8_count >= avail_after ? 16'h0080 : 16'h0000) | junk;
            cmd_read_id: rd = (flash_addr == pcr_id_addr ? {5'h00, partition_layout_config, 8'h00} : 16'h0000) | junk;
            default: rd = 16'h0000;
        endcase
    end
    // released bus shows the inverse so a stale sample cannot pass
    always @(posedge oe_n) last = rd;
    assign dq_in = (!ce_n && !oe_n) ? rd : ~last;
    assign ready_busy_output = sr[sel][7];
endmodule : flash_dev_model

// ==== verif/test_flash_status_host.sv ====
// self-checking bench for the flash status host against the device model
`timescale 1ns/10ps
module test_flash_status_host
    import flash_host_pkg::*;
();
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    op_t req_op = op_poll_status;
    logic [20:0] req_addr = 21'h0;
    logic req_ready, resp_valid, seq_ready, erase_suspended, erase_error, program_error, supply_low;
    logic program_suspended, lock_violation, bad_sequence, buffer_available, concurrent_allowed, timeout;
    logic ready_busy_output, dq_oe_n, ce_n, oe_n, we_n, t_done;
    logic [2:0] partition_code, partition_count;
    logic [15:0] dq_in, dq_out, st;
    logic [20:0] flash_addr;
    int cnt [8] = '{1, 2, 2, 3, 2, 3, 3, 4};
    int mismatches = 0;
    int cmp_count = 0;
    assign st = {8'h00, seq_ready, erase_suspended, erase_error, program_error, supply_low,
        program_suspended, lock_violation, bad_sequence};
    flash_status_host dut_u (.clock, .rst, .req_valid, .req_op, .req_addr, .req_ready, .resp_valid,
        .seq_ready, .erase_suspended, .erase_error, .program_error, .supply_low, .program_suspended,
        .lock_violation, .bad_sequence, .buffer_available, .partition_code, .partition_count,
        .concurrent_allowed, .timeout, .ready_busy_output, .dq_in, .dq_out, .dq_oe_n, .flash_addr,
        .ce_n, .oe_n, .we_n);
    flash_dev_model model_u (.ce_n, .oe_n, .we_n, .flash_addr, .dq_out, .dq_in, .ready_busy_output);
    initial forever #2 clock = ~clock;
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp
    // one request, then wait for its answer under a bound
    task automatic do_op(input op_t op, input logic [20:0] a);
        int n;
        t_done = 1'b0;
        req_op = op;
        req_addr = a;
        req_valid = 1'b1;
        @(posedge clock);
        #1 req_valid = 1'b0;
        for (n = 0; n < 5000; n++)
        begin
            @(posedge clock);
            #1;
            if (resp_valid === 1'b1)
                break;
        end
        cmp("answer", 16'h1, 16'(n < 5000));
        @(posedge clock);
        #1 t_done = 1'b1;
    endtask : do_op
    // flags expected from a raw status word; errors hidden while busy or on a bad sequence
    function automatic logic [15:0] exp_st(input logic [15:0] s);
        logic bad;
        bad = s[7] & s[5] & s[4];
        return s[7] ? {8'h00, 1'b1, s[6], s[5] & !bad, s[4] & !bad, s[3:1], bad} : 16'h0000;
    endfunction : exp_st
    task automatic poll(input logic [20:0] a, input logic [15:0] s);
        do_op(op_poll_status, a);
        cmp("status", exp_st(s), st);
    endtask : poll
    initial
    begin
        repeat (2) @(posedge clock);
        #1 rst = 1'b0;
        cmp("code", 16'h1, 16'(partition_code));
        $display("test reset done");
        // single flags, bad sequence and reserved bits, all in the upper partition
        for (int b = 1; b < 9; b++)
        begin
            model_u.sr[1] = b == 7 ? 16'h00b0 : b == 8 ? 16'hff81 : 16'h0080 | (16'h1 << b);
            poll(21'h100000, model_u.sr[1]);
        end
        // lower partition differs from the upper one so a wrong address shows
        model_u.sr[0] = 16'h0088;
        poll(21'h000000, 16'h0088);
        model_u.sr[1] = 16'h00be;
        do_op(op_clear, 21'h100000);
        poll(21'h100000, 16'h0080);
        $display("test flags done");
        model_u.sr[0] = 16'h0024;
        fork
            poll(21'h000000, 16'h00a0);
            begin
                repeat (300) @(posedge clock);
                #1 cmp("early", 16'h0, 16'(t_done));
                model_u.sr[0] = 16'h00a0;
            end
        join
        $display("test busy done");
        model_u.junk = 16'hff7f;
        model_u.avail_after = 5'h3;
        do_op(op_read_ext, 21'h0);
        cmp("buf", 16'h1, 16'(buffer_available));
        cmp("tries", 16'h3, 16'(model_u.e8_count));
        cmp("tmo", 16'h0, 16'(timeout));
        model_u.avail_after = 5'h1f;
        do_op(op_read_ext, 21'h0);
        cmp("buf", 16'h0, 16'(buffer_available));
        cmp("tmo", 16'h1, 16'(timeout));
        $display("test buffer done");
        model_u.junk = 16'hf8ff;
        for (int c = 0; c < 8; c++)
        begin
            model_u.partition_layout_config = 3'(c);
            do_op(op_read_layout, 21'h0);
            cmp("code", 16'(c), 16'(partition_code));
            cmp("parts", 16'(cnt[c]), 16'(partition_count));
            cmp("dual", 16'(c != 0), 16'(concurrent_allowed));
        end
        $display("test layout done");
        tally_and_finish();
    end
    // hang guard well beyond the expected few thousand cycles
    initial
    begin
        #200000;
        mismatches++;
        tally_and_finish();
    end
endmodule : test_flash_status_host
